// file: ppi_top.sv
// Pad pull inhibit register bank behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "ppi_consts.svh"
module ppi_top #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pad pull controls
    output ppi_pkg::ppi_sport_pd_t sport_pads,
    output ppi_pkg::ppi_pad_pull_t pin_pulls
);
    import ppi_pkg::*;

    localparam logic [ADDR_W-1:0] SPORT_ADDR = ADDR_W'({`PPI_IDX_SPORT, 2'b00});
    localparam logic [ADDR_W-1:0] TWO_ADDR = ADDR_W'({`PPI_IDX_TWO, 2'b00});

    // Word decode, low two address bits ignored
    function automatic ppi_sel_t reg_decode(input logic [ADDR_W-1:0] a);
        ppi_sel_t s;
        s = ppi_sel_none;
        if (a[ADDR_W-1:2] == SPORT_ADDR[ADDR_W-1:2]) begin
            s = ppi_sel_sport;
        end else if (a[ADDR_W-1:2] == TWO_ADDR[ADDR_W-1:2]) begin
            s = ppi_sel_two;
        end
        return s;
    endfunction

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    ppi_sel_t wr_sel;
    ppi_sel_t rd_sel;
    logic wr_sport;
    logic wr_two;
    logic [`PPI_REG_W-1:0] sport_q;
    logic [`PPI_REG_W-1:0] two_q;

    ppi_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Write steering; unmapped writes are dropped and answered with an error
    assign wr_sel = reg_decode(wr_addr);
    assign wr_sport = wr_en && (wr_sel == ppi_sel_sport);
    assign wr_two = wr_en && (wr_sel == ppi_sel_two);
    assign wr_err = (wr_sel == ppi_sel_none);

    // Serial pad pulldown inhibits, all set at reset
    ppi_inhibit_reg #(
        .WIDTH(`PPI_REG_W),
        .RST(`PPI_SPORT_RST),
        .WMASK(`PPI_SPORT_WMASK)
    ) u_serial_pad_pulldown_inhibit (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_sport),
        .wdata(wr_data[`PPI_REG_W-1:0]),
        .wstrb(wr_strb[1:0]),
        .q(sport_q)
    );

    // Pullup and address pulldown inhibits, bit 15 and bits 7..6 fixed at zero
    ppi_inhibit_reg #(
        .WIDTH(`PPI_REG_W),
        .RST(`PPI_TWO_RST),
        .WMASK(`PPI_TWO_WMASK)
    ) u_pullup_pulldown_inhibit_two (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_two),
        .wdata(wr_data[`PPI_REG_W-1:0]),
        .wstrb(wr_strb[1:0]),
        .q(two_q)
    );

    // Read mux, upper half of the word reads zero
    assign rd_sel = reg_decode(rd_addr);
    assign rd_err = (rd_sel == ppi_sel_none);
    assign rd_data = (rd_sel == ppi_sel_sport) ? {16'h0000, sport_q} :
                     (rd_sel == ppi_sel_two) ? {16'h0000, two_q} : 32'h0000_0000;

    // Serial port 1 pads
    assign sport_pads.sport1_pin5_pd_off = sport_q[13];
    assign sport_pads.sport1_pin4_pd_off = sport_q[12];
    assign sport_pads.sport1_pin3_pd_off = sport_q[11];
    assign sport_pads.sport1_pin2_pd_off = sport_q[10];
    assign sport_pads.sport1_pin1_pd_off = sport_q[9];
    assign sport_pads.sport1_pin0_pd_off = sport_q[8];
    // Serial port 0 pads
    assign sport_pads.sport0_pin5_pd_off = sport_q[5];
    assign sport_pads.sport0_pin4_pd_off = sport_q[4];
    assign sport_pads.sport0_pin3_pd_off = sport_q[3];
    assign sport_pads.sport0_pin2_pd_off = sport_q[2];
    assign sport_pads.sport0_pin1_pd_off = sport_q[1];
    assign sport_pads.sport0_pin0_pd_off = sport_q[0];
    // Control pin pullups
    assign pin_pulls.irq_pin1_pullup_off = two_q[14];
    assign pin_pulls.irq_pin0_pullup_off = two_q[13];
    assign pin_pulls.reset_pin_pullup_off = two_q[12];
    assign pin_pulls.emulation_pins_pullup_off = two_q[11];
    assign pin_pulls.jtag_data_in_pullup_off = two_q[10];
    assign pin_pulls.jtag_mode_select_pullup_off = two_q[9];
    assign pin_pulls.jtag_clock_pullup_off = two_q[8];
    // Upper address pad pulldowns
    assign pin_pulls.addr20_pulldown_off = two_q[5];
    assign pin_pulls.addr19_pulldown_off = two_q[4];
    assign pin_pulls.addr18_pulldown_off = two_q[3];
    assign pin_pulls.addr17_pulldown_off = two_q[2];
    assign pin_pulls.addr16_pulldown_off = two_q[1];
    assign pin_pulls.addr15_pulldown_off = two_q[0];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sport_reset_a: assert property (
        $past(!aresetn) |-> sport_pads == 12'hfff)
        else $error("Serial pulldown inhibits not all set after reset");

    sport_rsvd_a: assert property (
        sport_q[15:14] == 2'b00 && sport_q[7:6] == 2'b00)
        else $error("Serial register reserved bits nonzero");

    two_top_bit_a: assert property (
        two_q[`PPI_RSVD_HI] == 1'b0 && rd_data[31:16] == 16'h0000)
        else $error("Second register bit 15 or upper half nonzero");

    two_rsvd_a: assert property (
        two_q[7:6] == 2'b00)
        else $error("Second register bits 7..6 nonzero");

    pullup_reset_a: assert property (
        $past(!aresetn) |-> pin_pulls[12:6] == 7'h60)
        else $error("Pullup inhibit reset values wrong");

    sport1_write_a: assert property (
        wr_sport && wr_strb[1] |=> sport_pads[11:6] == $past(wr_data[13:8]))
        else $error("Serial port 1 inhibit write not applied");

    sport0_write_a: assert property (
        wr_sport && wr_strb[0] |=> sport_pads[5:0] == $past(wr_data[5:0]))
        else $error("Serial port 0 inhibit write not applied");

    pullup_write_a: assert property (
        wr_two && wr_strb[1] |=> pin_pulls[12:6] == $past(wr_data[14:8]))
        else $error("Pullup inhibit write not applied");

    addr_write_a: assert property (
        wr_two && wr_strb[0] |=> pin_pulls.addr20_pulldown_off == $past(wr_data[5])
            && pin_pulls[5:0] == $past(wr_data[5:0]))
        else $error("Address pulldown inhibit write not applied");

    pads_hold_a: assert property (
        !wr_en |=> $stable(sport_pads) && $stable(pin_pulls))
        else $error("Pad control changed without a write");

    read_back_a: assert property (
        arvalid && arready && rd_sel == ppi_sel_two
            |=> rvalid && rdata == {16'h0000, $past(two_q)} && rresp == `PPI_RESP_OKAY)
        else $error("Read did not return stored second register");

    addr_reset_a: assert property (
        $past(!aresetn) |-> pin_pulls[5:0] == 6'h3f)
        else $error("Address pulldown inhibit reset values wrong");

    sport_read_a: assert property (
        arvalid && arready && rd_sel == ppi_sel_sport
            |=> rvalid && rdata == {16'h0000, $past(sport_q)} && rresp == `PPI_RESP_OKAY)
        else $error("Read did not return stored serial register");

    unmapped_read_a: assert property (
        arvalid && arready && rd_err |=> rvalid && rdata == 32'h0000_0000 && rresp == `PPI_RESP_SLVERR)
        else $error("Unmapped read not answered with error");

    unmapped_err_a: assert property (
        wr_en && wr_err |=> bresp == `PPI_RESP_SLVERR && $stable(sport_q) && $stable(two_q))
        else $error("Unmapped write changed state or answered OKAY");

endmodule // ppi_top
`default_nettype wire

// file: ppi_consts.svh
// Offsets, field positions and reset values of the pad pull inhibit registers
`ifndef PPI_CONSTS_SVH
`define PPI_CONSTS_SVH

// Register width and word indexes (byte address is four times the index)
`define PPI_REG_W 16
`define PPI_IDX_SPORT 16'h1c17
`define PPI_IDX_TWO 16'h1c18

// Reset values and writable-bit masks
`define PPI_SPORT_RST 16'h3f3f
`define PPI_SPORT_WMASK 16'h3f3f
`define PPI_TWO_RST 16'h603f
`define PPI_TWO_WMASK 16'h7f3f

// Field positions
`define PPI_HI_LSB 8
`define PPI_LO_LSB 0
`define PPI_FIELD_W 6
`define PPI_PULLUP_W 7
`define PPI_RSVD_HI 15
`define PPI_RSVD_MID_LSB 6

// Bus responses
`define PPI_RESP_OKAY 2'h0
`define PPI_RESP_SLVERR 2'h2

`endif

// file: ppi_pkg.sv
// Types shared by the pad pull inhibit register bank
`default_nettype none
package ppi_pkg;

    typedef enum logic [1:0] {
        ppi_sel_none,
        ppi_sel_sport,
        ppi_sel_two
    } ppi_sel_t;

    typedef struct packed {
        logic sport1_pin5_pd_off;
        logic sport1_pin4_pd_off;
        logic sport1_pin3_pd_off;
        logic sport1_pin2_pd_off;
        logic sport1_pin1_pd_off;
        logic sport1_pin0_pd_off;
        logic sport0_pin5_pd_off;
        logic sport0_pin4_pd_off;
        logic sport0_pin3_pd_off;
        logic sport0_pin2_pd_off;
        logic sport0_pin1_pd_off;
        logic sport0_pin0_pd_off;
    } ppi_sport_pd_t;

    typedef struct packed {
        logic irq_pin1_pullup_off;
        logic irq_pin0_pullup_off;
        logic reset_pin_pullup_off;
        logic emulation_pins_pullup_off;
        logic jtag_data_in_pullup_off;
        logic jtag_mode_select_pullup_off;
        logic jtag_clock_pullup_off;
        logic addr20_pulldown_off;
        logic addr19_pulldown_off;
        logic addr18_pulldown_off;
        logic addr17_pulldown_off;
        logic addr16_pulldown_off;
        logic addr15_pulldown_off;
    } ppi_pad_pull_t;

endpackage
`default_nettype wire

// file: ppi_inhibit_reg.sv
// One inhibit register with per-bit reset values and read-only-zero reserved bits
`timescale 1ns/10ps
`default_nettype none
`include "ppi_consts.svh"
module ppi_inhibit_reg #(
    parameter int WIDTH = `PPI_REG_W,
    parameter logic [WIDTH-1:0] RST = '0,
    parameter logic [WIDTH-1:0] WMASK = '1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write port
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH/8-1:0] wstrb,
    // Stored value
    output logic [WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            if (WMASK[i]) begin : g_rw
                logic bit_q;
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        bit_q <= RST[i];
                    end else if (wr_en && wstrb[i/8]) begin
                        bit_q <= wdata[i];
                    end
                end
                assign q[i] = bit_q;
            end else begin : g_ro
                assign q[i] = 1'b0;
            end
        end
    endgenerate

    ro_bits_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (q & ~WMASK) == '0)
        else $error("Reserved bit reads nonzero");

endmodule // ppi_inhibit_reg
`default_nettype wire

// file: ppi_axil_slave.sv
// AXI4-Lite slave front end: up to two writes and one read in flight, registered answers
`timescale 1ns/10ps
`default_nettype none
`include "ppi_consts.svh"
module ppi_axil_slave #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register file side
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic awready_q, wready_q, arready_q;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic aw_fire, w_fire, ar_fire;
    logic [ADDR_W-1:0] addr_q;
    logic [31:0] data_q, rdata_q;
    logic [3:0] strb_q;
    logic [1:0] bresp_q, rresp_q;

    // Address and data are held until both are in and no response is pending
    assign aw_fire = awvalid && awready_q;
    assign w_fire = wvalid && wready_q;
    assign ar_fire = arvalid && arready_q;
    assign wr_en = aw_hold_q && w_hold_q && !bvalid_q;
    assign aw_hold_d = aw_fire || (aw_hold_q && !wr_en);
    assign w_hold_d = w_fire || (w_hold_q && !wr_en);
    assign bvalid_d = wr_en || (bvalid_q && !bready);
    assign rvalid_d = ar_fire || (rvalid_q && !rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            addr_q <= '0;
            data_q <= 32'h0000_0000;
            strb_q <= 4'h0;
            rdata_q <= 32'h0000_0000;
            bresp_q <= `PPI_RESP_OKAY;
            rresp_q <= `PPI_RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awready_q <= !aw_hold_d;
            wready_q <= !w_hold_d;
            arready_q <= !rvalid_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            if (aw_fire) begin
                addr_q <= awaddr;
            end
            if (w_fire) begin
                data_q <= wdata;
                strb_q <= wstrb;
            end
            if (wr_en) begin
                bresp_q <= wr_err ? `PPI_RESP_SLVERR : `PPI_RESP_OKAY;
            end
            if (ar_fire) begin
                rdata_q <= rd_data;
                rresp_q <= rd_err ? `PPI_RESP_SLVERR : `PPI_RESP_OKAY;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign wr_addr = addr_q;
    assign wr_data = data_q;
    assign wr_strb = strb_q;
    assign rd_addr = araddr;

    bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped before bready");

    rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("Read data dropped before rready");

    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en |=> bvalid)
        else $error("Committed write got no response next cycle");

endmodule // ppi_axil_slave
`default_nettype wire

// file: pad_pull_inhibit_regs_tb.sv
// Self-checking testbench of the pad pull inhibit register bank
`timescale 1ns/10ps
`default_nettype none
`include "ppi_consts.svh"
module pad_pull_inhibit_regs_tb;
    import ppi_pkg::*;
    localparam logic [15:0] ADR_SPORT = `PPI_IDX_SPORT << 2;
    localparam logic [15:0] ADR_TWO = `PPI_IDX_TWO << 2;
    localparam logic [15:0] ADR_NONE = 16'h7064;
    localparam int LIMIT = 5000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [15:0] araddr = '0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    ppi_sport_pd_t sport_pads;
    ppi_pad_pull_t pin_pulls;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] cur_s;
    logic [15:0] cur_t;

    ppi_top #(.ADDR_W(16)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sport_pads(sport_pads),
        .pin_pulls(pin_pulls));

    always #50 aclk = ~aclk;

    task automatic finish_test();
        $display("counts: %0d mismatches in %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            $display("mismatch at %0t: run did not complete", $time);
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0000, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                done = 1'b1;
                check({30'h0, bresp}, {30'h0, er}, "write response");
            end
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                done = 1'b1;
                check(rdata, exp, "read data");
                check({30'h0, rresp}, {30'h0, er}, "read response");
            end
        end
    endtask

    // Pads mirror the stored bits
    task automatic pad_chk();
        check({20'h0_0000, sport_pads}, {20'h0_0000, cur_s[13:8], cur_s[5:0]}, "serial pads");
        check({19'h0_0000, pin_pulls}, {19'h0_0000, cur_t[14:8], cur_t[5:0]}, "pin pulls");
    endtask

    task automatic t_defaults();
        cur_s = 16'h3f3f;
        cur_t = 16'h603f;
        rd_chk(ADR_SPORT, 32'h0000_3f3f, `PPI_RESP_OKAY);
        rd_chk(ADR_TWO, 32'h0000_603f, `PPI_RESP_OKAY);
        pad_chk();
    endtask

    // One bit at a time, reserved bits included
    task automatic t_sport_walk();
        for (int i = 0; i < 16; i++) begin
            wr(ADR_SPORT, 16'h0001 << i, 4'h3, `PPI_RESP_OKAY);
            cur_s = (16'h0001 << i) & 16'h3f3f;
            rd_chk(ADR_SPORT, {16'h0000, cur_s}, `PPI_RESP_OKAY);
            pad_chk();
        end
        wr(ADR_SPORT, 16'hffff, 4'h3, `PPI_RESP_OKAY);
        cur_s = 16'h3f3f;
        rd_chk(ADR_SPORT, 32'h0000_3f3f, `PPI_RESP_OKAY);
        wr(ADR_SPORT, 16'h0000, 4'h3, `PPI_RESP_OKAY);
        cur_s = 16'h0000;
        pad_chk();
    endtask

    task automatic t_two_walk();
        for (int i = 0; i < 16; i++) begin
            wr(ADR_TWO, 16'h0001 << i, 4'h3, `PPI_RESP_OKAY);
            cur_t = (16'h0001 << i) & 16'h7f3f;
            rd_chk(ADR_TWO, {16'h0000, cur_t}, `PPI_RESP_OKAY);
            pad_chk();
        end
        wr(ADR_TWO, 16'hffff, 4'h3, `PPI_RESP_OKAY);
        cur_t = 16'h7f3f;
        rd_chk(ADR_TWO, 32'h0000_7f3f, `PPI_RESP_OKAY);
        pad_chk();
    endtask

    // Byte lanes with strobe low keep their bits
    task automatic t_strobes();
        wr(ADR_TWO, 16'h0000, 4'h2, `PPI_RESP_OKAY);
        cur_t = 16'h003f;
        rd_chk(ADR_TWO, 32'h0000_003f, `PPI_RESP_OKAY);
        pad_chk();
        wr(ADR_TWO, 16'h7f00, 4'h1, `PPI_RESP_OKAY);
        cur_t = 16'h0000;
        rd_chk(ADR_TWO, 32'h0000_0000, `PPI_RESP_OKAY);
        pad_chk();
    endtask

    // Unmapped access leaves both registers and pads alone
    task automatic t_unmapped();
        wr(ADR_NONE, 16'hffff, 4'h3, `PPI_RESP_SLVERR);
        rd_chk(ADR_NONE, 32'h0000_0000, `PPI_RESP_SLVERR);
        rd_chk(ADR_SPORT, {16'h0000, cur_s}, `PPI_RESP_OKAY);
        rd_chk(ADR_TWO, {16'h0000, cur_t}, `PPI_RESP_OKAY);
        pad_chk();
    endtask

    // Write and read together, answers held until late bready and rready
    task automatic t_late_ready();
        logic [15:0] old_s;
        old_s = cur_s;
        @(posedge aclk);
        awaddr <= ADR_SPORT;
        awvalid <= 1'b1;
        wdata <= 32'h0000_2a15;
        wstrb <= 4'h3;
        wvalid <= 1'b1;
        araddr <= ADR_SPORT;
        arvalid <= 1'b1;
        while (awvalid || wvalid || arvalid || !bvalid || !rvalid) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        repeat (3) @(posedge aclk);
        check({31'h0, bvalid}, 32'h0000_0001, "write response held");
        check({31'h0, rvalid}, 32'h0000_0001, "read data held");
        check(rdata, {16'h0000, old_s}, "read beside write");
        cur_s = 16'h2a15;
        pad_chk();
        bready <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        rready <= 1'b0;
        check({30'h0, bresp}, {30'h0, `PPI_RESP_OKAY}, "late write response");
        check({30'h0, rresp}, {30'h0, `PPI_RESP_OKAY}, "late read response");
        @(posedge aclk);
        check({30'h0, bvalid, rvalid}, 32'h0000_0000, "answers taken");
        rd_chk(ADR_SPORT, 32'h0000_2a15, `PPI_RESP_OKAY);
    endtask

    // Reset in mid-run restores the defaults
    task automatic t_mid_reset();
        wr(ADR_TWO, 16'h1f00, 4'h3, `PPI_RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults();
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults();
        t_sport_walk();
        t_two_walk();
        t_strobes();
        t_unmapped();
        t_late_ready();
        t_mid_reset();
        finish_test();
    end
endmodule // pad_pull_inhibit_regs_tb
`default_nettype wire
